//--- rtl/cir_consts.vh
// constants for the charger control register bank
`ifndef CIR_CONSTS_VH
`define CIR_CONSTS_VH
// ----------------------------------------
// bus address and register offsets
// ----------------------------------------
`define CIR_SLAVE_ADDR 7'h4B
`define CIR_OFS_RESET 8'h00
`define CIR_OFS_CHARGE 8'h01
`define CIR_OFS_SWFREQ 8'h02
`define CIR_OFS_VBAT 8'h03
`define CIR_OFS_THERM 8'h04
`define CIR_OFS_VFLOOR 8'h05
`define CIR_OFS_EVENTS 8'h32
`define CIR_NUM_CTRL 6
// ----------------------------------------
// reset values
// ----------------------------------------
`define CIR_RST_RESET 8'h00
`define CIR_RST_CHARGE 8'h40
`define CIR_RST_SWFREQ 8'h00
`define CIR_RST_VBAT 8'h50
`define CIR_RST_THERM 8'hC0
`define CIR_RST_VFLOOR 8'h0A
// ----------------------------------------
// field positions
// ----------------------------------------
`define CIR_BIT_REGRST 7
`define CIR_BIT_CHGEN 7
`define CIR_BIT_REMIND 3
`define CIR_BIT_RATESEL 7
`define CIR_BIT_CONSTRATE 6
`define CIR_BIT_SPREAD 5
// ----------------------------------------
// timing
// ----------------------------------------
`define CIR_CLK_MHZ 100
`define CIR_STARTUP_US 500
`define CIR_REMIND_MS 2000
`define CIR_REMIND_GAP_US 1
`endif

//--- rtl/cir_sync2.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
module cir_sync2 #(
    parameter W = 1
) (
    input wire clk, // system clock
    input wire rst_n, // async reset, active low
    input wire [W-1:0] d, // asynchronous input
    output reg [W-1:0] q // synchronised output
);
    reg [W-1:0] meta_r; // first stage, read only by q

    // ----------------------------------------
    // two stages, nothing taps the first
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

//--- rtl/cir_timer.v
// free-running interval timer with a one-cycle tick
`timescale 1ns/1ns
module cir_timer #(
    parameter W = 28,
    parameter [W-1:0] LIMIT = 28'd10
) (
    input wire clk, // system clock
    input wire rst_n, // async reset, active low
    input wire clear, // holds the count at zero
    output reg tick // pulse every LIMIT cycles
);
    localparam [W-1:0] LAST = LIMIT - {{(W-1){1'b0}}, 1'b1};
    reg [W-1:0] cnt_r; // elapsed cycles

    // ----------------------------------------
    // count and wrap
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= {W{1'b0}};
            tick <= 1'b0;
        end else begin
            tick <= ~clear & (cnt_r == LAST);
            if (clear || cnt_r == LAST) begin
                cnt_r <= {W{1'b0}};
            end else begin
                cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

//--- rtl/cir_regbank.v
// two-wire slave control register bank of the charger
`timescale 1ns/1ns
`include "cir_consts.vh"
module cir_regbank #(
    parameter STARTUP_CYCLES = `CIR_STARTUP_US * `CIR_CLK_MHZ,
    parameter REMIND_CYCLES = `CIR_REMIND_MS * 1000 * `CIR_CLK_MHZ
) (
    input wire clk, // system clock, 100 MHz
    input wire rst_n, // async reset, active low
    input wire sclIn, // bus clock pin level
    input wire sdaIn, // bus data pin level
    output wire sdaOut, // bus data drive value
    output reg sdaOe, // high while pulling data low
    input wire enablePin, // device enable pin
    input wire wdtResetReq, // watchdog reset pulse
    input wire [7:0] eventIn, // event pulses, same clock
    input wire [7:0] eventMask, // 1 masks an event
    output wire intOut, // interrupt drive value
    output reg intOe, // high while pulling interrupt low
    output reg deviceReady, // device operational
    output reg chargeEnableBit, // charging allowed
    output wire switchingRateSelect, // 1 selects half rate
    output wire constantRateBit, // 1 fixes the frequency
    output wire spreadSpectrumBit, // 1 enables spreading
    output wire [5:0] batteryTargetVoltageCode, // battery target
    output wire [1:0] thermalLimitCode, // thermal limit
    output wire [6:0] inputVoltageFloorCode // input floor
);
    // ----------------------------------------
    // states and timing
    // ----------------------------------------
    localparam [7:0] ST_IDLE = 8'h01;
    localparam [7:0] ST_ADDR = 8'h02;
    localparam [7:0] ST_AACK = 8'h04;
    localparam [7:0] ST_REG = 8'h08;
    localparam [7:0] ST_WDATA = 8'h10;
    localparam [7:0] ST_DACK = 8'h20;
    localparam [7:0] ST_RDATA = 8'h40;
    localparam [7:0] ST_RACK = 8'h80;
    localparam [7:0] GAP_CYCLES = `CIR_REMIND_GAP_US * `CIR_CLK_MHZ;

    // default value of a control register
    function [7:0] defVal;
        input [7:0] idx;
        begin
            case (idx)
                `CIR_OFS_RESET: defVal = `CIR_RST_RESET;
                `CIR_OFS_CHARGE: defVal = `CIR_RST_CHARGE;
                `CIR_OFS_SWFREQ: defVal = `CIR_RST_SWFREQ;
                `CIR_OFS_VBAT: defVal = `CIR_RST_VBAT;
                `CIR_OFS_THERM: defVal = `CIR_RST_THERM;
                `CIR_OFS_VFLOOR: defVal = `CIR_RST_VFLOOR;
                default: defVal = 8'h00;
            endcase
        end
    endfunction

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    reg [7:0] ctrl_r [0:`CIR_NUM_CTRL-1]; // control registers
    reg [7:0] evt_r; // read-clear event flags
    reg [7:0] state_r; // bus state
    reg [3:0] bitCnt_r; // bits in current byte
    reg [7:0] rxSh_r; // receive shifter
    reg [7:0] txSh_r; // transmit shifter
    reg [7:0] ptr_r; // register pointer
    reg rw_r; // 1 for a read transfer
    reg nack_r; // host declined more data
    reg wrStb_r; // register write pulse
    reg [7:0] wrAddr_r; // write target
    reg [7:0] wrData_r; // write value
    reg rdClr_r; // flags were loaded for reading
    reg regRst_r; // reset bit was written with 1
    reg sclP_r; // previous bus clock
    reg sdaP_r; // previous bus data
    reg [7:0] gapCnt_r; // reminder release time left
    reg [7:0] rdNow; // byte at the pointer
    wire sclS; // synced bus clock
    wire sdaS; // synced bus data
    wire enS; // synced enable pin
    wire startTick; // start-up delay expired
    wire remindTick; // reminder interval expired
    wire pending; // unmasked event waiting
    wire softReset; // restore register defaults
    wire sclRise;
    wire sclFall;
    wire startCond;
    wire stopCond;
    integer i;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    cir_sync2 #(.W(3)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({sclIn, sdaIn, enablePin}),
        .q({sclS, sdaS, enS})
    );

    // delayed copies for edge detection, off the second stage only
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclP_r <= 1'b0;
            sdaP_r <= 1'b0;
        end else begin
            sclP_r <= sclS;
            sdaP_r <= sdaS;
        end
    end

    assign sclRise = sclS & ~sclP_r;
    assign sclFall = ~sclS & sclP_r;
    assign startCond = sclS & sclP_r & sdaP_r & ~sdaS;
    assign stopCond = sclS & sclP_r & ~sdaP_r & sdaS;

    // ----------------------------------------
    // enable and start-up delay
    // ----------------------------------------
    cir_timer #(.W(32), .LIMIT(STARTUP_CYCLES - 3)) u_start ( // sync and ready flop add 3 cycles
        .clk(clk),
        .rst_n(rst_n),
        .clear(~enS | deviceReady),
        .tick(startTick)
    );

    // ready follows the start-up tick, drops the cycle after the synced pin goes low
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            deviceReady <= 1'b0;
        end else if (!enS) begin
            deviceReady <= 1'b0;
        end else if (startTick) begin
            deviceReady <= 1'b1;
        end
    end

    // ----------------------------------------
    // register file
    // ----------------------------------------
    // disabled device, watchdog or reset bit all restore defaults
    assign softReset = regRst_r | wdtResetReq | ~deviceReady;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < `CIR_NUM_CTRL; i = i + 1) begin
                ctrl_r[i] <= defVal(i[7:0]);
            end
            regRst_r <= 1'b0;
        end else if (softReset) begin
            // the written 1 is visible for one cycle, then clears
            for (i = 0; i < `CIR_NUM_CTRL; i = i + 1) begin
                ctrl_r[i] <= defVal(i[7:0]);
            end
            regRst_r <= 1'b0;
        end else if (wrStb_r && wrAddr_r < `CIR_NUM_CTRL) begin
            ctrl_r[wrAddr_r[2:0]] <= wrData_r;
            regRst_r <= (wrAddr_r == `CIR_OFS_RESET) & wrData_r[`CIR_BIT_REGRST];
        end
    end

    // flags: clear only the bits just sent, so a late event is kept; set wins
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            evt_r <= 8'h00;
        end else begin
            evt_r <= (softReset ? 8'h00 : evt_r & ~({8{rdClr_r}} & txSh_r)) | eventIn;
        end
    end

    // read mux, unmapped offsets read zero
    always @* begin
        rdNow = 8'h00;
        if (ptr_r < `CIR_NUM_CTRL) begin
            rdNow = ctrl_r[ptr_r[2:0]];
        end else if (ptr_r == `CIR_OFS_EVENTS) begin
            rdNow = evt_r;
        end
    end

    // ----------------------------------------
    // field outputs
    // ----------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            chargeEnableBit <= 1'b0;
        end else begin
            chargeEnableBit <= ctrl_r[1][`CIR_BIT_CHGEN] & deviceReady;
        end
    end

    assign switchingRateSelect = ctrl_r[2][`CIR_BIT_RATESEL];
    assign constantRateBit = ctrl_r[2][`CIR_BIT_CONSTRATE];
    assign spreadSpectrumBit = ctrl_r[2][`CIR_BIT_SPREAD];
    assign batteryTargetVoltageCode = ctrl_r[3][7:2];
    assign thermalLimitCode = ctrl_r[4][7:6];
    assign inputVoltageFloorCode = ctrl_r[5][7:1];

    // ----------------------------------------
    // interrupt and reminder
    // ----------------------------------------
    assign pending = |(evt_r & ~eventMask);

    // interval runs only while reminding is on and an unmasked event is pending
    cir_timer #(.W(32), .LIMIT(REMIND_CYCLES)) u_remind (
        .clk(clk),
        .rst_n(rst_n),
        .clear(~(ctrl_r[1][`CIR_BIT_REMIND] & pending)),
        .tick(remindTick)
    );

    // short release window so the host sees a fresh falling edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            gapCnt_r <= 8'h00;
        end else if (remindTick) begin
            gapCnt_r <= GAP_CYCLES;
        end else if (gapCnt_r != 8'h00) begin
            gapCnt_r <= gapCnt_r - 8'h01;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            intOe <= 1'b0;
        end else begin
            intOe <= pending & deviceReady & (gapCnt_r == 8'h00);
        end
    end

    assign intOut = 1'b0; // open drain: only ever pulls low
    assign sdaOut = 1'b0; // open drain data

    // ----------------------------------------
    // bus slave state machine
    // ----------------------------------------
    // samples data on clock rise, changes drive on clock fall
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            bitCnt_r <= 4'h0;
            rxSh_r <= 8'h00;
            txSh_r <= 8'h00;
            ptr_r <= 8'h00;
            rw_r <= 1'b0;
            nack_r <= 1'b0;
            sdaOe <= 1'b0;
            wrStb_r <= 1'b0;
            wrAddr_r <= 8'h00;
            wrData_r <= 8'h00;
            rdClr_r <= 1'b0;
        end else begin
            wrStb_r <= 1'b0;
            rdClr_r <= 1'b0;
            if (!deviceReady) begin
                // disabled: deaf to the bus
                state_r <= ST_IDLE;
                sdaOe <= 1'b0;
            end else if (startCond) begin
                // start or repeated start, pointer is kept
                state_r <= ST_ADDR;
                bitCnt_r <= 4'h0;
                sdaOe <= 1'b0;
            end else if (stopCond) begin
                state_r <= ST_IDLE;
                sdaOe <= 1'b0;
            end else begin
                case (state_r)
                    ST_IDLE: begin
                        sdaOe <= 1'b0;
                    end
                    ST_ADDR, ST_REG, ST_WDATA: begin
                        if (sclRise) begin
                            rxSh_r <= {rxSh_r[6:0], sdaS};
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end else if (sclFall && bitCnt_r == 4'h8) begin
                            bitCnt_r <= 4'h0;
                            if (state_r == ST_ADDR) begin
                                if (rxSh_r[7:1] == `CIR_SLAVE_ADDR) begin
                                    sdaOe <= 1'b1;
                                    rw_r <= rxSh_r[0];
                                    state_r <= ST_AACK;
                                end else begin
                                    state_r <= ST_IDLE;
                                end
                            end else if (state_r == ST_REG) begin
                                ptr_r <= rxSh_r;
                                sdaOe <= 1'b1;
                                state_r <= ST_DACK;
                            end else begin
                                // flags are read-clear, writes there are dropped
                                wrStb_r <= 1'b1;
                                wrAddr_r <= ptr_r;
                                wrData_r <= rxSh_r;
                                ptr_r <= ptr_r + 8'h01;
                                sdaOe <= 1'b1;
                                state_r <= ST_DACK;
                            end
                        end
                    end
                    ST_AACK, ST_RACK: begin
                        if (sclRise && state_r == ST_RACK) begin
                            nack_r <= sdaS;
                        end else if (sclFall) begin
                            if (state_r == ST_AACK && !rw_r) begin
                                sdaOe <= 1'b0;
                                state_r <= ST_REG;
                            end else if (state_r == ST_RACK && nack_r) begin
                                sdaOe <= 1'b0;
                                state_r <= ST_IDLE;
                            end else begin
                                txSh_r <= rdNow;
                                sdaOe <= ~rdNow[7];
                                rdClr_r <= (ptr_r == `CIR_OFS_EVENTS);
                                ptr_r <= ptr_r + 8'h01;
                                bitCnt_r <= 4'h0;
                                nack_r <= 1'b0;
                                state_r <= ST_RDATA;
                            end
                        end
                    end
                    ST_DACK: begin
                        if (sclFall) begin
                            sdaOe <= 1'b0;
                            state_r <= ST_WDATA;
                        end
                    end
                    ST_RDATA: begin
                        if (sclRise) begin
                            bitCnt_r <= bitCnt_r + 4'h1;
                        end else if (sclFall) begin
                            if (bitCnt_r == 4'h8) begin
                                sdaOe <= 1'b0;
                                bitCnt_r <= 4'h0;
                                state_r <= ST_RACK;
                            end else begin
                                txSh_r <= {txSh_r[6:0], 1'b0};
                                sdaOe <= ~txSh_r[6];
                            end
                        end
                    end
                    default: begin
                        state_r <= ST_IDLE;
                        sdaOe <= 1'b0;
                    end
                endcase
            end
        end
    end
endmodule

//--- sim/cir_regbank_monitor.sv
// port checker for the charger control register bank
`timescale 1ns/1ns
module cir_regbank_monitor #(
    parameter STARTUP_CYCLES = 20,
    parameter REMIND_CYCLES = 200
) (
    input wire clk, // clock
    input wire rst_n, // reset
    input wire sclIn, // bus clock
    input wire sdaIn, // bus data
    input wire sdaOut, // data drive
    input wire sdaOe, // data pull
    input wire enablePin, // enable
    input wire wdtResetReq, // watchdog
    input wire [7:0] eventIn, // events
    input wire [7:0] eventMask, // masks
    input wire intOut, // irq drive
    input wire intOe, // irq pull
    input wire deviceReady, // ready
    input wire chargeEnableBit, // charging
    input wire switchingRateSelect, // half rate
    input wire constantRateBit, // fixed rate
    input wire spreadSpectrumBit, // spreading
    input wire [5:0] batteryTargetVoltageCode, // battery
    input wire [1:0] thermalLimitCode, // thermal
    input wire [6:0] inputVoltageFloorCode // floor
);
    // ready must come within the start-up budget
    localparam int RDY_MAX = STARTUP_CYCLES;
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    ready_drop_a:
        assert property ($fell(enablePin) |-> ##[1:5] !deviceReady)
        else $error("ready held with enable low");
    pins_idle_a:
        assert property (!deviceReady [*2] |-> !sdaOe && !intOe)
        else $error("pin pulled while not ready");
    startup_a:
        assert property ($rose(enablePin) |-> ##[1:RDY_MAX] (deviceReady || !enablePin))
        else $error("ready late after enable");
    early_a:
        assert property ($rose(deviceReady) |-> $past(enablePin, 8))
        else $error("ready without enable");
    chg_gate_a:
        assert property (!deviceReady [*2] |-> !chargeEnableBit)
        else $error("charging while disabled");
    freq_dflt_a:
        assert property (!deviceReady [*2] |-> !switchingRateSelect && !constantRateBit && !spreadSpectrumBit)
        else $error("rate bits not default");
    code_dflt_a:
        assert property (!deviceReady [*2] |-> batteryTargetVoltageCode == 6'h14 && thermalLimitCode == 2'h3
            && inputVoltageFloorCode == 7'h05)
        else $error("codes not default");
    wdt_dflt_a:
        assert property (wdtResetReq |-> ##2 (batteryTargetVoltageCode == 6'h14 && !chargeEnableBit))
        else $error("watchdog left settings");
    irq_set_a:
        assert property (deviceReady && (eventIn & ~eventMask) != 8'h00 |-> ##[1:3] intOe)
        else $error("event not signalled");
    irq_masked_a:
        assert property ((eventMask == 8'hFF) [*2] |-> !intOe)
        else $error("masked event raised");
    cover property ($rose(intOe));
    cover property ($fell(intOe) && deviceReady);
    cover property ($rose(chargeEnableBit));
    cover property ($rose(sdaOe));
endmodule

bind cir_regbank cir_regbank_monitor #(
    .STARTUP_CYCLES(STARTUP_CYCLES),
    .REMIND_CYCLES(REMIND_CYCLES)
) i_mon (
    .clk(clk), .rst_n(rst_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .enablePin(enablePin), .wdtResetReq(wdtResetReq), .eventIn(eventIn), .eventMask(eventMask),
    .intOut(intOut), .intOe(intOe), .deviceReady(deviceReady), .chargeEnableBit(chargeEnableBit),
    .switchingRateSelect(switchingRateSelect), .constantRateBit(constantRateBit),
    .spreadSpectrumBit(spreadSpectrumBit), .batteryTargetVoltageCode(batteryTargetVoltageCode),
    .thermalLimitCode(thermalLimitCode), .inputVoltageFloorCode(inputVoltageFloorCode)
);

//--- sim/cir_host_model.sv
// host bus master model for the charger register bank
`timescale 1ns/1ns
module cir_host_model #(
    parameter HALF = 10
) (
    input wire clk, // system clock
    input wire sdaLine, // resolved data line
    output reg scl, // bus clock, never stretched
    output reg sdaLow // high while pulling data low
);
    initial begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task wt(input integer n);
        begin
            repeat (n) @(posedge clk);
            #1;
        end
    endtask
    // data moves mid-low, line is sampled at the end of the high phase
    task bit_tx(input b, output r);
        begin
            wt(HALF / 2);
            sdaLow = !b;
            wt(HALF / 2);
            scl = 1'b1;
            wt(HALF);
            r = sdaLine;
            scl = 1'b0;
        end
    endtask
    // sending ones releases the line, so one task reads and writes
    task byte_xfer(input [7:0] tx, input last, output [7:0] rx, output ack);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                bit_tx(tx[i], r);
                rx[i] = r;
            end
            bit_tx(last, r);
            ack = !r;
        end
    endtask
    task start;
        begin
            wt(HALF / 2);
            sdaLow = 1'b0;
            wt(HALF / 2);
            scl = 1'b1;
            wt(HALF);
            sdaLow = 1'b1;
            wt(HALF);
            scl = 1'b0;
        end
    endtask
    task stop;
        begin
            wt(HALF / 2);
            sdaLow = 1'b1;
            wt(HALF / 2);
            scl = 1'b1;
            wt(HALF);
            sdaLow = 1'b0;
            wt(HALF);
        end
    endtask
    task write_reg(input [6:0] dev, input [7:0] ofs, input [7:0] val, output ok);
        reg [7:0] d;
        reg a0;
        reg a1;
        reg a2;
        begin
            start;
            byte_xfer({dev, 1'b0}, 1'b1, d, a0);
            byte_xfer(ofs, 1'b1, d, a1);
            byte_xfer(val, 1'b1, d, a2);
            stop;
            ok = a0 & a1 & a2;
        end
    endtask
    task read_reg(input [7:0] ofs, output [7:0] val);
        reg [7:0] d;
        reg a;
        begin
            start;
            byte_xfer(8'h96, 1'b1, d, a);
            byte_xfer(ofs, 1'b1, d, a);
            start;
            byte_xfer(8'h97, 1'b1, d, a);
            byte_xfer(8'hFF, 1'b1, val, a);
            stop;
        end
    endtask
endmodule

//--- sim/tb_top.sv
// self-checking bench for the charger control register bank
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam [47:0] DFLT = 48'h0AC050004000; // defaults, offset 0 lowest
    localparam [47:0] WRV = 48'hC080FCA08800; // values written to 1..5
    reg clk = 1'b0;
    reg rst_n = 1'b0;
    reg enablePin = 1'b1;
    reg wdtResetReq = 1'b0;
    reg [7:0] eventIn = 8'h00;
    reg [7:0] eventMask = 8'h00;
    wire scl, sdaLow, sdaLine, sdaOut, sdaOe, intOut, intOe, deviceReady, chargeEnableBit;
    wire switchingRateSelect, constantRateBit, spreadSpectrumBit;
    wire [5:0] batteryTargetVoltageCode;
    wire [1:0] thermalLimitCode;
    wire [6:0] inputVoltageFloorCode;
    reg [7:0] v;
    reg ok;
    integer n;
    integer badCount = 0;
    integer nTests = 0;
    // a released data line floats up through its pull-up
    assign sdaLine = ((sdaOe & ~sdaOut) | sdaLow) ? 1'b0 : 1'b1;
    always #5 clk = ~clk;
    // short counts keep the run brief
    cir_regbank #(.STARTUP_CYCLES(20), .REMIND_CYCLES(200)) i_dut (
        .clk(clk), .rst_n(rst_n), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .enablePin(enablePin), .wdtResetReq(wdtResetReq), .eventIn(eventIn), .eventMask(eventMask),
        .intOut(intOut), .intOe(intOe), .deviceReady(deviceReady), .chargeEnableBit(chargeEnableBit),
        .switchingRateSelect(switchingRateSelect), .constantRateBit(constantRateBit),
        .spreadSpectrumBit(spreadSpectrumBit), .batteryTargetVoltageCode(batteryTargetVoltageCode),
        .thermalLimitCode(thermalLimitCode), .inputVoltageFloorCode(inputVoltageFloorCode)
    );
    cir_host_model i_host (.clk(clk), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task cyc(input integer c);
        begin
            repeat (c) @(posedge clk);
            #1;
        end
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        begin
            nTests = nTests + 1;
            if (seen !== exp) begin
                badCount = badCount + 1;
                $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask
    task wait_ready;
        begin
            n = 0;
            while (deviceReady !== 1'b1 && n < 100) begin
                cyc(1);
                n = n + 1;
            end
        end
    endtask
    task check_out(input [7:0] c1, input [7:0] c2, input [7:0] c3, input [7:0] c4, input [7:0] c5);
        begin
            check(chargeEnableBit, c1[7]);
            check({switchingRateSelect, constantRateBit, spreadSpectrumBit}, c2[7:5]);
            check(batteryTargetVoltageCode, c3[7:2]);
            check(thermalLimitCode, c4[7:6]);
            check(inputVoltageFloorCode, c5[7:1]);
        end
    endtask
    task read_all(input [47:0] exp);
        integer i;
        begin
            for (i = 0; i < 6; i = i + 1) begin
                i_host.read_reg(i[7:0], v);
                check(v, exp[8 * i +: 8]);
            end
        end
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_fields;
        integer i;
        begin
            for (i = 1; i < 6; i = i + 1) begin
                i_host.write_reg(7'h4B, i[7:0], WRV[8 * i +: 8], ok);
                check(ok, 1'b1);
            end
            check_out(8'h88, 8'hA0, 8'hFC, 8'h80, 8'hC0);
            read_all(WRV);
            // a neighbouring address must be ignored
            i_host.write_reg(7'h4A, 8'h03, 8'h00, ok);
            check(ok, 1'b0);
            check(batteryTargetVoltageCode, 6'h3F);
        end
    endtask
    task t_events;
        begin
            eventMask = 8'hFF;
            eventIn = 8'h01;
            cyc(1);
            eventIn = 8'h00;
            cyc(4);
            check(intOe, 1'b0);
            eventMask = 8'h00;
            eventIn = 8'h10;
            cyc(1);
            eventIn = 8'h00;
            cyc(3);
            check({intOe, intOut}, 2'h2);
            n = 0;
            while (intOe === 1'b1 && n < 400) begin
                cyc(1);
                n = n + 1;
            end
            check(intOe, 1'b0);
            n = 0;
            while (intOe === 1'b0 && n < 200) begin
                cyc(1);
                n = n + 1;
            end
            check(n > 90 && n < 110, 1'b1);
            i_host.read_reg(8'h32, v);
            check(v, 8'h11);
            cyc(3);
            check(intOe, 1'b0);
            i_host.read_reg(8'h32, v);
            check(v, 8'h00);
        end
    endtask
    task t_resets;
        begin
            i_host.write_reg(7'h4B, 8'h00, 8'h80, ok);
            read_all(DFLT);
            i_host.write_reg(7'h4B, 8'h04, 8'h00, ok);
            i_host.write_reg(7'h4B, 8'h03, 8'h3C, ok);
            check(thermalLimitCode, 2'h0);
            wdtResetReq = 1'b1;
            cyc(1);
            wdtResetReq = 1'b0;
            cyc(3);
            check_out(8'h40, 8'h00, 8'h50, 8'hC0, 8'h0A);
        end
    endtask
    task t_enable;
        begin
            i_host.write_reg(7'h4B, 8'h01, 8'h80, ok);
            check(chargeEnableBit, 1'b1);
            enablePin = 1'b0;
            cyc(8);
            check({deviceReady, chargeEnableBit}, 2'h0);
            enablePin = 1'b1;
            wait_ready;
            check(n <= 20, 1'b1);
        end
    endtask
    // ----------------------------------------
    // run control
    // ----------------------------------------
    task printVerdict;
        begin
            $display("checks %0d mismatches %0d", nTests, badCount);
            if (badCount == 0 && nTests > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    // tests take about 23k cycles, so 100k means a hang
    initial begin
        #1000000;
        badCount = badCount + 1;
        printVerdict;
    end
    initial begin
        cyc(16);
        rst_n = 1'b1;
        wait_ready;
        read_all(DFLT);
        check_out(8'h40, 8'h00, 8'h50, 8'hC0, 8'h0A);
        t_fields;
        t_events;
        t_resets;
        t_enable;
        printVerdict;
    end
endmodule
